// [rtl/scmc_top.sv]
// system clock mode control: control register, power mode sequencing, ready flags
// assumes oscillator ticks, halt and wake are one-cycle pulses synchronous to mclk
module scmc_top
  import scmc_pkg::*;
#(
  parameter logic [SCMC_CNT_W-1:0] LO_XTAL_CYC = SCMC_LO_XTAL_SETTLE,
  parameter logic [SCMC_CNT_W-1:0] LO_RC_CYC   = SCMC_LO_RC_SETTLE,
  parameter logic [SCMC_CNT_W-1:0] HI_XTAL_CYC = SCMC_HI_XTAL_SETTLE,
  parameter logic [SCMC_CNT_W-1:0] HRC_CYC     = SCMC_HRC_SETTLE
) (
  input  wire logic          mclk,
  input  wire logic          nrst,
  input  scmc_bus_req_t      bus_req,
  output logic [7:0]         rdata_q,
  input  scmc_hsrc_t         hsrc_cfg,
  input  scmc_lsrc_t         lsrc_cfg,
  input  wire logic          hi_osc_tick,
  input  wire logic          lo_osc_tick,
  input  wire logic          halt_pulse,
  input  wire logic          wake_pulse,
  input  wire logic          idle_sysclk_on,
  input  wire logic          sub_keep_on,
  output scmc_pmode_t        pmode_q,
  output scmc_clk_src_t      clk_src_q,
  output logic [2:0]         div_shift_q,
  output logic               cpu_run_q,
  output logic               irq_q
);

  scmc_ctrl_t                ctrl_q, ctrl_d;
  scmc_pmode_t               pmode_d;
  scmc_clk_src_t             clk_src_d;
  logic [2:0]                div_shift_d;
  logic                      cpu_run_d, irq_d, wake_fast_q, wake_fast_d;
  logic [SCMC_INT_W-1:0]     stat_q, stat_d, en_q, en_d, ev;
  logic [7:0]                rdata_d;
  logic                      lo_rdy, hi_rdy, lo_prev_q, hi_prev_q;
  logic                      lo_run, hi_run, low_sel, need_rdy;
  logic [SCMC_CNT_W-1:0]     lo_target, hi_target;

  // 000 and 001 both pick the low-speed clock while the divided path is chosen
  function automatic logic sel_is_low(input scmc_ctrl_t c);
    return !c.high_low_clock_select && (c.clock_divide_select[2:1] == 2'b00);
  endfunction : sel_is_low

  // divide exponent: 010 gives 2^6, 111 gives 2^1
  function automatic logic [2:0] div_log2(input logic [2:0] sel);
    return 3'h7 - (sel - 3'h1);
  endfunction : div_log2

  assign low_sel   = sel_is_low(ctrl_q);
  assign lo_target = (lsrc_cfg == LSRC_LO_XTAL) ? LO_XTAL_CYC : LO_RC_CYC;
  assign hi_target = (hsrc_cfg == HSRC_HI_XTAL) ? HI_XTAL_CYC : HRC_CYC;
  assign lo_run    = (pmode_q != PM_SLEEP0);
  // high oscillator stops in slow running and in the deep states
  assign hi_run    = !low_sel && ((pmode_q == PM_RUN) || (pmode_q == PM_IDLE1) ||
                                  (pmode_q == PM_WAKE));
  assign need_rdy  = low_sel ? lo_rdy : hi_rdy;

  scmc_settle #(.CNT_W(SCMC_CNT_W)) u_lo_settle (
    .mclk    (mclk),
    .nrst    (nrst),
    .run     (lo_run),
    .tick    (lo_osc_tick),
    .target  (lo_target),
    .ready_q (lo_rdy)
  );

  scmc_settle #(.CNT_W(SCMC_CNT_W)) u_hi_settle (
    .mclk    (mclk),
    .nrst    (nrst),
    .run     (hi_run),
    .tick    (hi_osc_tick),
    .target  (hi_target),
    .ready_q (hi_rdy)
  );

  // register port
  always_comb begin
    ctrl_d  = ctrl_q;
    en_d    = en_q;
    rdata_d = 8'h00;
    if (bus_req.wr) begin
      case (bus_req.addr)
        SCMC_OFS_CTRL: begin
          ctrl_d                     = scmc_ctrl_t'(bus_req.wdata);
          ctrl_d.low_osc_ready_flag  = 1'b0;
          ctrl_d.high_osc_ready_flag = 1'b0;
        end
        SCMC_OFS_INT_EN: en_d = bus_req.wdata[SCMC_INT_W-1:0];
        default: ;
      endcase
    end
    if (bus_req.rd) begin
      case (bus_req.addr)
        SCMC_OFS_CTRL: begin
          rdata_d                  = ctrl_q;
          rdata_d[SCMC_BIT_LO_RDY] = lo_rdy;
          rdata_d[SCMC_BIT_HI_RDY] = hi_rdy;
        end
        SCMC_OFS_INT_STAT: rdata_d = {{(8-SCMC_INT_W){1'b0}}, stat_q};
        SCMC_OFS_INT_EN:   rdata_d = {{(8-SCMC_INT_W){1'b0}}, en_q};
        default:           rdata_d = 8'h00;
      endcase
    end
  end

  // power mode sequencing
  always_comb begin
    pmode_d     = pmode_q;
    wake_fast_d = wake_fast_q;
    ev          = '0;
    case (pmode_q)
      PM_RUN: begin
        if (halt_pulse) begin
          if (ctrl_q.idle_on_halt) begin
            pmode_d = idle_sysclk_on ? PM_IDLE1 : PM_IDLE0;
          end else begin
            pmode_d = sub_keep_on ? PM_SLEEP1 : PM_SLEEP0;
          end
        end
      end
      PM_SLEEP0, PM_SLEEP1, PM_IDLE0, PM_IDLE1: begin
        if (wake_pulse) begin
          pmode_d = PM_WAKE;
          // sleep0 has no substitute clock, idle1 keeps its own clock
          wake_fast_d = ctrl_q.fast_wake_enable && (hsrc_cfg == HSRC_HI_XTAL) &&
                        ((pmode_q == PM_SLEEP1) || (pmode_q == PM_IDLE0)) &&
                        !low_sel;
        end
      end
      PM_WAKE: begin
        if (need_rdy) begin
          pmode_d     = PM_RUN;
          wake_fast_d = 1'b0;
          ev[SCMC_INT_WAKE] = 1'b1;
        end
      end
      default: pmode_d = PM_RUN;
    endcase
    ev[SCMC_INT_LOW_RDY]  = lo_rdy && !lo_prev_q;
    ev[SCMC_INT_HIGH_RDY] = hi_rdy && !hi_prev_q;
  end

  // clock routing; run and idle1 use the low clock until the high one has settled, a fast wake uses the substitute clock
  always_comb begin
    clk_src_d   = CLK_OFF;
    div_shift_d = 3'h0;
    if (!ctrl_q.high_low_clock_select && !low_sel) begin
      div_shift_d = div_log2(ctrl_q.clock_divide_select);
    end else begin
      div_shift_d = 3'h0;
    end
    case (pmode_q)
      PM_RUN, PM_IDLE1: clk_src_d = (low_sel || !hi_rdy) ? CLK_LOW : CLK_HIGH;
      PM_WAKE:          clk_src_d = (wake_fast_q && !hi_rdy) ? CLK_SUB : CLK_OFF;
      default:          clk_src_d = CLK_OFF;
    endcase
    cpu_run_d = (pmode_q == PM_RUN) || ((pmode_q == PM_WAKE) && wake_fast_q);
  end

  // sticky status: a new event wins over a clear in the same cycle
  always_comb begin
    stat_d = stat_q | ev;
    if (bus_req.wr && (bus_req.addr == SCMC_OFS_INT_CLR)) begin
      stat_d = (stat_q & ~bus_req.wdata[SCMC_INT_W-1:0]) | ev;
    end
    irq_d = |(stat_d & en_d);
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ctrl_q      <= scmc_ctrl_t'(SCMC_CTRL_RESET);
      en_q        <= '0;
      stat_q      <= '0;
      rdata_q     <= 8'h00;
      pmode_q     <= PM_RUN;
      wake_fast_q <= 1'b0;
      clk_src_q   <= CLK_LOW;
      div_shift_q <= 3'h0;
      cpu_run_q   <= 1'b0;
      irq_q       <= 1'b0;
      lo_prev_q   <= 1'b0;
      hi_prev_q   <= 1'b0;
    end else begin
      ctrl_q      <= ctrl_d;
      en_q        <= en_d;
      stat_q      <= stat_d;
      rdata_q     <= rdata_d;
      pmode_q     <= pmode_d;
      wake_fast_q <= wake_fast_d;
      clk_src_q   <= clk_src_d;
      div_shift_q <= div_shift_d;
      cpu_run_q   <= cpu_run_d;
      irq_q       <= irq_d;
      lo_prev_q   <= lo_rdy;
      hi_prev_q   <= hi_rdy;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_fast_wake_done;
    (pmode_q == PM_WAKE) && wake_fast_q && hi_rdy && !low_sel;
  endsequence

  chk_halt_to_sleep0: assert property ((pmode_q == PM_RUN) && halt_pulse &&
    !ctrl_q.idle_on_halt && !sub_keep_on |=> pmode_q == PM_SLEEP0)
    else $error("halt did not enter sleep0");
  chk_halt_to_idle1: assert property ((pmode_q == PM_RUN) && halt_pulse &&
    ctrl_q.idle_on_halt && idle_sysclk_on |=> pmode_q == PM_IDLE1)
    else $error("halt did not enter idle1");
  chk_low_clock_sel: assert property ((pmode_q == PM_RUN) && low_sel
    |=> clk_src_q == CLK_LOW) else $error("low clock not selected");
  chk_div_by_64: assert property (!ctrl_q.high_low_clock_select &&
    (ctrl_q.clock_divide_select == 3'h2) |=> div_shift_q == 3'h6)
    else $error("code 010 did not divide by 64");
  chk_div_by_2: assert property (!ctrl_q.high_low_clock_select &&
    (ctrl_q.clock_divide_select == 3'h7) |=> div_shift_q == 3'h1)
    else $error("code 111 did not divide by 2");
  chk_undivided_high: assert property (ctrl_q.high_low_clock_select
    |=> div_shift_q == 3'h0) else $error("selector applied with high bit set");
  chk_fast_sub_clock: assert property ((pmode_q == PM_WAKE) && wake_fast_q &&
    !hi_rdy |=> (clk_src_q == CLK_SUB) && cpu_run_q)
    else $error("fast wake not on substitute clock");
  chk_fast_only_xtal: assert property (wake_pulse && (pmode_q != PM_RUN) &&
    (pmode_q != PM_WAKE) && (hsrc_cfg != HSRC_HI_XTAL) |=> !wake_fast_q)
    else $error("fast wake used without high crystal");
  chk_low_flag_sleep0: assert property ((pmode_q == PM_SLEEP0)
    |=> !lo_rdy) else $error("low ready flag set in sleep0");
  chk_switch_to_xtal: assert property (s_fast_wake_done
    |=> (pmode_q == PM_RUN) ##1 (clk_src_q == CLK_HIGH))
    else $error("no switch to high crystal after settle");
  chk_flags_read_live: assert property (bus_req.rd && (bus_req.addr == SCMC_OFS_CTRL)
    |=> (rdata_q[SCMC_BIT_LO_RDY] == $past(lo_rdy)) &&
        (rdata_q[SCMC_BIT_HI_RDY] == $past(hi_rdy)))
    else $error("ready flags not read from hardware");

endmodule : scmc_top

// [common/scmc_pkg.sv]
// constants, field layout and types of the system clock mode control block
// assumes a single synchronous clock domain and an 8-bit register port
package scmc_pkg;

  localparam int unsigned SCMC_ADDR_W = 4;
  localparam int unsigned SCMC_DATA_W = 8;
  localparam int unsigned SCMC_CNT_W  = 11;
  localparam int unsigned SCMC_INT_W  = 3;

  localparam logic [3:0] SCMC_OFS_CTRL     = 4'h0;
  localparam logic [3:0] SCMC_OFS_INT_STAT = 4'h1;
  localparam logic [3:0] SCMC_OFS_INT_EN   = 4'h2;
  localparam logic [3:0] SCMC_OFS_INT_CLR  = 4'h3;

  localparam int unsigned SCMC_BIT_DIV_LSB = 5;
  localparam int unsigned SCMC_BIT_FST     = 4;
  localparam int unsigned SCMC_BIT_LO_RDY  = 3;
  localparam int unsigned SCMC_BIT_HI_RDY  = 2;
  localparam int unsigned SCMC_BIT_IDLE    = 1;
  localparam int unsigned SCMC_BIT_HL      = 0;

  localparam logic [7:0] SCMC_CTRL_RESET = 8'h03;

  localparam int unsigned SCMC_INT_LOW_RDY  = 0;
  localparam int unsigned SCMC_INT_HIGH_RDY = 1;
  localparam int unsigned SCMC_INT_WAKE     = 2;

  // settle times in cycles of the oscillator concerned
  localparam logic [10:0] SCMC_LO_XTAL_SETTLE = 11'h400;
  localparam logic [10:0] SCMC_LO_RC_SETTLE   = 11'h002;
  localparam logic [10:0] SCMC_HI_XTAL_SETTLE = 11'h400;
  localparam logic [10:0] SCMC_HRC_SETTLE     = 11'h010;

  typedef enum logic [1:0] {HSRC_HI_XTAL, HSRC_ERC, HSRC_HIRC} scmc_hsrc_t;
  typedef enum logic {LSRC_LO_XTAL, LSRC_LO_RC} scmc_lsrc_t;
  typedef enum logic [1:0] {CLK_HIGH, CLK_LOW, CLK_SUB, CLK_OFF} scmc_clk_src_t;
  typedef enum logic [2:0] {
    PM_RUN, PM_SLEEP0, PM_SLEEP1, PM_IDLE0, PM_IDLE1, PM_WAKE
  } scmc_pmode_t;

  typedef struct packed {
    logic [2:0] clock_divide_select;
    logic       fast_wake_enable;
    logic       low_osc_ready_flag;
    logic       high_osc_ready_flag;
    logic       idle_on_halt;
    logic       high_low_clock_select;
  } scmc_ctrl_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } scmc_bus_req_t;

endpackage : scmc_pkg

// [rtl/scmc_settle.sv]
// oscillator settle counter: ready after a set number of oscillator ticks
// assumes tick is a one-cycle pulse per oscillator cycle, synchronous to mclk
module scmc_settle
  import scmc_pkg::*;
#(
  parameter int unsigned CNT_W = SCMC_CNT_W
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic             run,
  input  wire logic             tick,
  input  wire logic [CNT_W-1:0] target,
  output logic                  ready_q
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             ready_d;

  // a stopped oscillator loses its settled state at once
  always_comb begin
    cnt_d   = cnt_q;
    ready_d = ready_q;
    if (!run) begin
      cnt_d   = '0;
      ready_d = 1'b0;
    end else if (tick && !ready_q) begin
      cnt_d = cnt_q + 1'b1;
      if (cnt_q == target - 1'b1) begin
        ready_d = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cnt_q   <= '0;
      ready_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      ready_q <= ready_d;
    end
  end

  chk_stop_clears_ready: assert property (@(posedge mclk) disable iff (!nrst)
    !run |=> !ready_q) else $error("ready stayed set with oscillator stopped");

endmodule : scmc_settle

// [tb/tb_top.sv]
// self-checking bench for the system clock mode control block
// assumes scmc_pkg is compiled first; drives all ports directly, no partner model
module tb_top
  import scmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic          mclk;
  logic          nrst;
  logic          hi_t;
  logic          lo_t;
  logic          halt_p;
  logic          wake_p;
  logic          isys;
  logic          skeep;
  scmc_bus_req_t req;
  scmc_hsrc_t    hsrc;
  scmc_lsrc_t    lsrc;
  logic [7:0]    rdata;
  scmc_pmode_t   pmode;
  scmc_clk_src_t csrc;
  logic [2:0]    dsh;
  logic          cpu_run;
  logic          irq;
  logic [7:0]    rv;
  int            error_cnt;
  int            num_checks;
  scmc_pmode_t   exp_m [4] = '{PM_SLEEP0, PM_SLEEP1, PM_IDLE0, PM_IDLE1};

  // crystal and high rc settle counts shortened, low rc kept at its default, so that every wake finishes in a few ticks
  scmc_top #(
    .LO_XTAL_CYC (11'h004),
    .LO_RC_CYC   (11'h002),
    .HI_XTAL_CYC (11'h004),
    .HRC_CYC     (11'h004)
  ) u_dut (
    .mclk           (mclk),
    .nrst           (nrst),
    .bus_req        (req),
    .rdata_q        (rdata),
    .hsrc_cfg       (hsrc),
    .lsrc_cfg       (lsrc),
    .hi_osc_tick    (hi_t),
    .lo_osc_tick    (lo_t),
    .halt_pulse     (halt_p),
    .wake_pulse     (wake_p),
    .idle_sysclk_on (isys),
    .sub_keep_on    (skeep),
    .pmode_q        (pmode),
    .clk_src_q      (csrc),
    .div_shift_q    (dsh),
    .cpu_run_q      (cpu_run),
    .irq_q          (irq)
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk

  // waits n edges, then steps past the edge so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge mclk);
    req.wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge mclk);
    req.rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  // one tick of both oscillators every second cycle
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      hi_t <= 1'b1;
      lo_t <= 1'b1;
      @(posedge mclk);
      hi_t <= 1'b0;
      lo_t <= 1'b0;
    end
  endtask : tick

  task automatic pulse(input logic w);
    @(posedge mclk);
    if (w) wake_p <= 1'b1;
    else halt_p <= 1'b1;
    @(posedge mclk);
    wake_p <= 1'b0;
    halt_p <= 1'b0;
  endtask : pulse

  task automatic wait_run;
    // step past the edge before looking, the state may change on it
    for (int i = 0; i < 50 && pmode !== PM_RUN; i++) begin
      tick(1);
      #1;
    end
    cyc(2);
  endtask : wait_run

  initial begin
    #300000;
    error_cnt++;
    stop_test();
  end

  initial begin
    nrst = 1'b0;
    req = '0;
    hsrc = HSRC_HI_XTAL;
    lsrc = LSRC_LO_XTAL;
    {hi_t, lo_t, halt_p, wake_p, isys, skeep} = 6'h00;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    cyc(2);
    chk("cpu_run", 8'h01, cpu_run);
    rd(SCMC_OFS_CTRL, rv);
    chk("ctrl reset", 8'h03, rv);
    wr(SCMC_OFS_CTRL, 8'hff);
    rd(SCMC_OFS_CTRL, rv);
    chk("ctrl ready bits", 8'hf3, rv);
    tick(6);
    rd(SCMC_OFS_CTRL, rv);
    chk("ctrl ready live", 8'hff, rv);
    chk("div_shift", 8'h00, dsh);
    chk("clk_src", CLK_HIGH, csrc);
    $display("test reset_and_flags done");
    for (int c = 7; c >= 0; c--) begin
      wr(SCMC_OFS_CTRL, {c[2:0], 5'h00});
      tick(6);
      cyc(1);
      if (c > 1) begin
        chk("clk_src", CLK_HIGH, csrc);
        chk("div_shift", 8'(8 - c), dsh);
      end else begin
        chk("clk_src", CLK_LOW, csrc);
      end
    end
    $display("test divide_select done");
    for (int m = 0; m < 4; m++) begin
      wr(SCMC_OFS_CTRL, {6'h00, m[1], 1'b1});
      isys  <= m[0];
      skeep <= m[0];
      pulse(1'b0);
      cyc(2);
      chk("pmode", exp_m[m], pmode);
      chk("cpu_run", 8'h00, cpu_run);
      rd(SCMC_OFS_CTRL, rv);
      chk("low ready in halt", 8'(m != 0), rv[3]);
      pulse(1'b1);
      wait_run();
      tick(6);
      rd(SCMC_OFS_CTRL, rv);
      chk("low ready after wake", 8'h01, rv[3]);
      chk("pmode", PM_RUN, pmode);
    end
    $display("test halt_modes done");
    rd(SCMC_OFS_INT_STAT, rv);
    chk("int_stat", 8'h07, rv);
    wr(SCMC_OFS_INT_STAT, 8'h00);
    rd(SCMC_OFS_INT_STAT, rv);
    chk("int_stat read only", 8'h07, rv);
    wr(SCMC_OFS_INT_EN, 8'h01);
    cyc(2);
    chk("irq", 8'h01, irq);
    rd(SCMC_OFS_INT_EN, rv);
    chk("int_en", 8'h01, rv);
    wr(SCMC_OFS_INT_CLR, 8'h01);
    cyc(2);
    chk("irq masked", 8'h00, irq);
    rd(SCMC_OFS_INT_STAT, rv);
    chk("int_stat cleared", 8'h06, rv);
    rd(SCMC_OFS_INT_CLR, rv);
    chk("int_clr", 8'h00, rv);
    rd(4'h9, rv);
    chk("unmapped", 8'h00, rv);
    wr(SCMC_OFS_INT_EN, 8'h04);
    cyc(2);
    chk("irq wake", 8'h01, irq);
    wr(SCMC_OFS_INT_CLR, 8'h06);
    cyc(2);
    chk("irq clear", 8'h00, irq);
    $display("test interrupts done");
    // case 0 fast wake on crystal, 1 fast wake off, 2 internal rc ignores it
    // case 1 also runs the low clock from the internal rc, which settles sooner
    for (int k = 0; k < 3; k++) begin
      @(posedge mclk);
      nrst <= 1'b0;
      hsrc <= (k == 2) ? HSRC_HIRC : HSRC_HI_XTAL;
      lsrc <= (k == 1) ? LSRC_LO_RC : LSRC_LO_XTAL;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      cyc(2);
      tick(2);
      rd(SCMC_OFS_CTRL, rv);
      chk("low ready short settle", 8'(k == 1), rv[3]);
      tick(4);
      wr(SCMC_OFS_CTRL, (k == 1) ? 8'h01 : 8'h11);
      pulse(1'b0);
      cyc(3);
      pulse(1'b1);
      cyc(3);
      chk("cpu_run on wake", 8'(k == 0), cpu_run);
      if (k == 0) begin
        chk("clk_src on wake", CLK_SUB, csrc);
        rd(SCMC_OFS_CTRL, rv);
        chk("high ready early", 8'h00, rv[2]);
      end
      wait_run();
      chk("clk_src after wake", CLK_HIGH, csrc);
    end
    $display("test fast_wake done");
    stop_test();
  end

endmodule : tb_top
